// *** ctw_core_timer.sv ***
// Core timer with overflow flag, periodic tick flag and watchdog.
//
// How it works
// - Watchdog timeout comes from the selected tick divided by eight.
// - A watchdog timeout raises an internal reset pulse to the reset logic.
// - Writing zero to bit 0 of the clear address services the watchdog.
// - A service clears only the divide-by-eight stage, nothing else.
// - The watchdog stage always counts; its reset pulse is raised only when the build option enables it.
// - The count register is read-only, shows the ripple counter, reset clears it.
// - Control/status bits 2 and 3 are write-only and read as zero.
// - Rate select picks tick divide two to the 14 up to 17.
// - Writing one to tick acknowledge clears the tick flag; zero does nothing.
// - Writing one to overflow acknowledge clears the overflow flag.
// - Tick enable, reset to zero, gates the tick flag onto the interrupt.
// - Overflow enable, reset to zero, gates the overflow flag onto the interrupt.
// - Tick flag sets when the selected divider stage goes active; reset clears.
// - Overflow flag sets when the ripple counter wraps from all ones.
// - Writes straight to a flag bit leave it unchanged.
// - Leaving stop or reset waits 224 or 4064 cycles of stabilisation.
// - Stop halts the watchdog; counting resumes after the stabilisation delay.
// - The counter's last stage clocks a 7-bit divider; top four stages tick.
// - The chain runs at bus clock rate and keeps running in wait mode.
// - Reset clears the whole counter chain at any time.
//
// Strobed register access was decided locally.
module ctw_core_timer #(
  parameter bit WDOG_EN = 1'b1,
  parameter bit STAB_LONG_SEL = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [ctw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ctw_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_stop,
  output logic [ctw_pkg::DATA_W-1:0] o_rdata,
  output logic o_timer_irq,
  output logic o_wdog_rst,
  output logic o_stab_busy
);
  import ctw_pkg::*;

  localparam logic [STAB_W-1:0] STAB_LEN = STAB_LONG_SEL ? STAB_LONG : STAB_SHORT;

  logic [PRE_W-1:0] pre_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_inc;
  logic [WDOG_W-1:0] wdog_reg;
  logic [STAB_W-1:0] stab_reg;
  logic stop_q_reg;
  logic tick_flag_reg;
  logic ovf_flag_reg;
  logic tick_en_reg;
  logic ovf_en_reg;
  logic [1:0] rate_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic wdog_rst_reg;
  logic run;
  logic pre_wrap;
  logic ovf_evt;
  logic tick_evt;
  logic wdog_svc;
  logic csr_wr;
  logic [2:0] tick_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // Stop handling and stabilisation delay.

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      stab_reg <= STAB_LEN;
      stop_q_reg <= 1'b0;
    end else begin
      stop_q_reg <= i_stop;
      if (stop_q_reg && !i_stop) begin
        stab_reg <= STAB_LEN;
      end else if (stab_reg != '0) begin
        stab_reg <= stab_reg - 1'b1;
      end
    end
  end

  assign o_stab_busy = (stab_reg != '0);

  assign run = !i_stop && !o_stab_busy;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter chain.

  assign pre_wrap = run && (pre_reg == PRE_LAST);
  assign ovf_evt = pre_wrap && (cnt_reg == CNT_LAST);
  assign div_inc = div_reg + 1'b1;
  assign tick_bit = TICK_BASE + {1'b0, rate_reg};
  assign tick_evt = ovf_evt && !div_reg[tick_bit] && div_inc[tick_bit];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end else if (run) begin
      pre_reg <= pre_reg + 1'b1;
      if (pre_wrap) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      div_reg <= '0;
    end else if (ovf_evt) begin
      div_reg <= div_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog stage.

  assign wdog_svc = i_wr && (i_addr == WDOG_CLR_ADDR) && !i_wdata[WDOG_SVC_BIT];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wdog_reg <= '0;
    end else if (wdog_svc) begin
      wdog_reg <= '0;
    end else if (tick_evt) begin
      wdog_reg <= wdog_reg + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wdog_rst_reg <= 1'b0;
    end else begin
      wdog_rst_reg <= WDOG_EN && tick_evt && !wdog_svc && (wdog_reg == WDOG_LAST);
    end
  end

  assign o_wdog_rst = wdog_rst_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  assign csr_wr = i_wr && (i_addr == CSR_OFF);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tick_en_reg <= 1'b0;
      ovf_en_reg <= 1'b0;
      rate_reg <= 2'h0;
    end else if (csr_wr) begin
      tick_en_reg <= i_wdata[TICK_EN_BIT];
      ovf_en_reg <= i_wdata[OVF_EN_BIT];
      rate_reg <= {i_wdata[RATE_HI_BIT], i_wdata[RATE_LO_BIT]};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tick_flag_reg <= 1'b0;
    end else if (tick_evt) begin
      tick_flag_reg <= 1'b1;
    end else if (csr_wr && i_wdata[TICK_ACK_BIT]) begin
      tick_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ovf_flag_reg <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_reg <= 1'b1;
    end else if (csr_wr && i_wdata[OVF_ACK_BIT]) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rdata_reg <= '0;
    end else if (i_rd && (i_addr == CSR_OFF)) begin
      rdata_reg <= {tick_flag_reg, ovf_flag_reg, tick_en_reg, ovf_en_reg, 2'h0, rate_reg};
    end else if (i_rd && (i_addr == CNT_OFF)) begin
      rdata_reg <= cnt_reg;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign o_rdata = rdata_reg;

  assign o_timer_irq = (tick_flag_reg && tick_en_reg) || (ovf_flag_reg && ovf_en_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence stop_exit_s;
    $fell(i_stop);
  endsequence

  sequence stab_hold_s;
    o_stab_busy [*8];
  endsequence

  chk_stab_after_stop: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn) stop_exit_s |=> stab_hold_s)
    else $error("stabilisation delay did not start after stop exit");

  chk_stop_halts_wdog: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_stop && !wdog_svc) |=> (wdog_reg == $past(wdog_reg)) && !o_wdog_rst)
    else $error("watchdog moved during stop");

  chk_ovf_sets_flag: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    ovf_evt |=> ovf_flag_reg && (cnt_reg == '0))
    else $error("overflow flag not set on counter wrap");

  chk_tick_sets_flag: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn) tick_evt |=> tick_flag_reg)
    else $error("tick flag not set on tick");

  chk_tick_ack_clear: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (csr_wr && i_wdata[TICK_ACK_BIT] && !tick_evt) |=> !tick_flag_reg)
    else $error("tick acknowledge did not clear flag");

  chk_flag_write_ignored: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (csr_wr && !i_wdata[OVF_ACK_BIT] && ovf_flag_reg) |=> ovf_flag_reg)
    else $error("write without acknowledge cleared overflow flag");

  chk_csr_rsvd_zero: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && (i_addr == CSR_OFF)) |=> (o_rdata[TICK_ACK_BIT] == 1'b0) &&
    (o_rdata[OVF_ACK_BIT] == 1'b0) && (o_rdata[TICK_EN_BIT] == tick_en_reg))
    else $error("write-only bits read back nonzero");

  chk_irq_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (tick_flag_reg && !tick_en_reg && !(ovf_flag_reg && ovf_en_reg)) |-> !o_timer_irq)
    else $error("masked tick flag raised interrupt");

  chk_wdog_timeout: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (tick_evt && (wdog_reg == WDOG_LAST) && !wdog_svc) |=> (o_wdog_rst == WDOG_EN))
    else $error("watchdog timeout did not reset");

  chk_svc_clears_stage: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (wdog_svc && run && !pre_wrap) |=> (wdog_reg == '0) && (cnt_reg == $past(cnt_reg)) &&
    (pre_reg == $past(pre_reg) + 1'b1))
    else $error("watchdog service disturbed chain");

  chk_reset_clears: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(i_rstn) |-> (cnt_reg == '0) && (div_reg == '0) && (wdog_reg == '0))
    else $error("reset did not clear counter chain");

  chk_rdata_idle: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_rd |=> (o_rdata == '0))
    else $error("read data not zero outside a read");

  chk_count_read: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (i_rd && (i_addr == CNT_OFF)) |=> (o_rdata == $past(cnt_reg)))
    else $error("count read returned wrong value");

  chk_ovf_ack_clear: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (csr_wr && i_wdata[OVF_ACK_BIT] && !ovf_evt) |=> !ovf_flag_reg)
    else $error("overflow acknowledge did not clear flag");

  chk_tick_write_kept: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (csr_wr && !i_wdata[TICK_ACK_BIT] && tick_flag_reg) |=> tick_flag_reg)
    else $error("write without acknowledge cleared tick flag");

  chk_tick_irq_set: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (tick_flag_reg && tick_en_reg) |-> o_timer_irq)
    else $error("enabled tick flag did not raise interrupt");

  chk_ovf_irq_set: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (ovf_flag_reg && ovf_en_reg) |-> o_timer_irq)
    else $error("enabled overflow flag did not raise interrupt");

  chk_ovf_irq_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    (ovf_flag_reg && !ovf_en_reg && !(tick_flag_reg && tick_en_reg)) |-> !o_timer_irq)
    else $error("masked overflow flag raised interrupt");

  chk_count_step: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    pre_wrap |=> (cnt_reg == $past(cnt_reg) + 1'b1))
    else $error("counter did not step on prescaler wrap");

  chk_count_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !pre_wrap |=> (cnt_reg == $past(cnt_reg)))
    else $error("counter moved between prescaler wraps");

  chk_div_step: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    ovf_evt |=> (div_reg == $past(div_reg) + 1'b1))
    else $error("divider did not step on counter wrap");

  chk_div_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !ovf_evt |=> (div_reg == $past(div_reg)))
    else $error("divider moved without counter wrap");

  chk_tick_on_wrap: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_evt |-> ovf_evt)
    else $error("tick seen without counter wrap");

  chk_wdog_pulse_short: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    o_wdog_rst |=> !o_wdog_rst)
    else $error("watchdog reset pulse longer than one cycle");

  chk_svc_wins: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    wdog_svc |=> (wdog_reg == '0) && !o_wdog_rst)
    else $error("watchdog service did not clear stage");

  chk_stab_reload: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    stop_exit_s |=> (stab_reg == STAB_LEN))
    else $error("stabilisation delay not reloaded on stop exit");

  chk_busy_halts: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    o_stab_busy |=> (pre_reg == $past(pre_reg)))
    else $error("chain ran during stabilisation delay");

  chk_wdog_masked: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !WDOG_EN |-> !o_wdog_rst)
    else $error("watchdog reset raised while option is off");

  chk_stop_freezes: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_stop |=> (cnt_reg == $past(cnt_reg)) && (div_reg == $past(div_reg)))
    else $error("counter chain moved during stop");

  chk_rate_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    csr_wr |=> (rate_reg == {$past(i_wdata[RATE_HI_BIT]), $past(i_wdata[RATE_LO_BIT])}))
    else $error("rate select not taken from write");

endmodule

// *** ctw_pkg.sv ***
// Constants shared by the core timer: register map, field positions and chain sizes.
package ctw_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register map.
  localparam logic [15:0] CSR_OFF = 16'h0008;
  localparam logic [15:0] CNT_OFF = 16'h0009;
  localparam logic [15:0] WDOG_CLR_ADDR = 16'h1FF0;

  // Control/status field positions.
  localparam int TICK_FLAG_BIT = 7;
  localparam int OVF_FLAG_BIT = 6;
  localparam int TICK_EN_BIT = 5;
  localparam int OVF_EN_BIT = 4;
  localparam int TICK_ACK_BIT = 3;
  localparam int OVF_ACK_BIT = 2;
  localparam int RATE_HI_BIT = 1;
  localparam int RATE_LO_BIT = 0;
  localparam int WDOG_SVC_BIT = 0;

  // Counter chain: prescaler, ripple counter, tick divider, watchdog stage.
  localparam int PRE_W = 2;
  localparam int CNT_W = 8;
  localparam int DIV_W = 7;
  localparam int WDOG_W = 3;
  localparam logic [2:0] TICK_BASE = 3'h3;
  localparam logic [PRE_W-1:0] PRE_LAST = 2'h3;
  localparam logic [CNT_W-1:0] CNT_LAST = 8'hFF;
  localparam logic [WDOG_W-1:0] WDOG_LAST = 3'h7;

  // Oscillator stabilisation delay after stop or reset, in clock cycles.
  localparam int STAB_W = 12;
  localparam logic [STAB_W-1:0] STAB_SHORT = 12'h0E0;
  localparam logic [STAB_W-1:0] STAB_LONG = 12'hFE0;

endpackage

// *** ctw_rst_model.sv ***
// Reset logic model that counts watchdog reset requests from the timer.
module ctw_rst_model (
  input wire logic i_ref_clk,
  input wire logic i_wdog_rst,
  output int o_pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pulses = 0;
  always @(posedge i_ref_clk) begin
    if (i_wdog_rst === 1'b1) begin
      o_pulses <= o_pulses + 1;
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking testbench for the core timer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ctw_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_stop = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic o_timer_irq;
  logic o_wdog_rst;
  logic o_stab_busy;
  logic [7:0] a;
  int wd_pulses;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  int t1;
  ctw_core_timer #(.WDOG_EN(1'b1), .STAB_LONG_SEL(1'b0)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_stop(i_stop), .o_rdata(o_rdata),
    .o_timer_irq(o_timer_irq), .o_wdog_rst(o_wdog_rst), .o_stab_busy(o_stab_busy));
  ctw_rst_model model_u (.i_ref_clk(i_ref_clk), .i_wdog_rst(o_wdog_rst), .o_pulses(wd_pulses));
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // Cuts a hang short; the full run needs about 82700 cycles.
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 105000) begin
      errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_int(string nm, int e, int g);
    cmp_count++;
    if (g != e) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(logic [15:0] ad, logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    step();
    i_wr <= 1'b0;
    step();
  endtask
  task automatic rd(logic [15:0] ad, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= ad;
    step();
    i_rd <= 1'b0;
    d = o_rdata;
    step();
  endtask
  task automatic rchk(string nm, logic [15:0] ad, logic [7:0] e);
    logic [7:0] v;
    rd(ad, v);
    chk8(nm, e, v);
  endtask
  task automatic wait_irq(int lim, output int t);
    int n = 0;
    while (o_timer_irq !== 1'b1 && n < lim) begin
      step();
      n++;
    end
    chk1("irq raised", 1'b1, o_timer_irq);
    t = cyc;
  endtask
  // Checks the state right after a reset release and the stabilisation delay.
  task automatic after_reset();
    step();
    chk1("busy reset", 1'b1, o_stab_busy);
    rchk("csr reset", CSR_OFF, 8'h00);
    rchk("count reset", CNT_OFF, 8'h00);
    repeat (190) step();
    chk1("busy hold", 1'b1, o_stab_busy);
    repeat (40) step();
    chk1("busy end", 1'b0, o_stab_busy);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    after_reset();
    wr(CSR_OFF, 8'h10);
    wait_irq(1100, t0);
    rchk("csr ovf", CSR_OFF, 8'h50);
    wr(CSR_OFF, 8'h50);
    rchk("csr flag write", CSR_OFF, 8'h50);
    wr(CSR_OFF, 8'h14);
    rchk("csr ovf ack", CSR_OFF, 8'h10);
    chk1("irq ovf ack", 1'b0, o_timer_irq);
    rd(CNT_OFF, a);
    wr(CNT_OFF, 8'hFF);
    repeat (36) step();
    rchk("count pace", CNT_OFF, a + 8'h0A);
    rchk("unmapped", 16'h0010, 8'h00);
    i_stop <= 1'b1;
    repeat (2) step();
    rd(CNT_OFF, a);
    repeat (50) step();
    rchk("count stop", CNT_OFF, a);
    i_stop <= 1'b0;
    repeat (3) step();
    chk1("busy stop", 1'b1, o_stab_busy);
    rchk("count stab", CNT_OFF, a);
    repeat (240) step();
    chk1("busy stop end", 1'b0, o_stab_busy);
    wr(CSR_OFF, 8'h20);
    wait_irq(17000, t0);
    rchk("csr tick", CSR_OFF, 8'hE0);
    wr(CSR_OFF, 8'h2C);
    wr(WDOG_CLR_ADDR, 8'h00);
    rchk("csr acks", CSR_OFF, 8'h20);
    wait_irq(17000, t1);
    chk_int("tick period 0", 16384, t1 - t0);
    wr(CSR_OFF, 8'h29);
    wr(CSR_OFF, 8'h29);
    wait_irq(34000, t0);
    wr(CSR_OFF, 8'h29);
    wait_irq(34000, t1);
    chk_int("tick period 1", 32768, t1 - t0);
    chk_int("wdog pulses", 0, wd_pulses);
    wr(CSR_OFF, 8'h00);
    i_rstn <= 1'b0;
    repeat (8) step();
    i_rstn <= 1'b1;
    after_reset();
    tally_and_finish();
  end
endmodule
